// ### dps_map.svh
// Named offsets, field positions, reset values and timing figures of the deflection sequencer.
`ifndef DPS_MAP_SVH
`define DPS_MAP_SVH

// Register bus geometry.
`define DPS_AW 8
`define DPS_DW 32
`define DPS_ADDR_CTRL 8'h00
`define DPS_ADDR_STATUS 8'h04
`define DPS_ADDR_ONTIME 8'h08

// Control register fields.
`define DPS_CTRL_W 5
`define DPS_CTRL_RESET 5'h01
`define DPS_CTRL_STANDBY 0
`define DPS_CTRL_FBC_EN 1
`define DPS_CTRL_OVS_SEL 2
`define DPS_CTRL_TDIS_SEL 3
`define DPS_CTRL_ESS 4

// Status register fields.
`define DPS_ST_STATE_LO 0
`define DPS_ST_PLL 4
`define DPS_ST_DIS 5
`define DPS_ST_OVS 6
`define DPS_ST_DRIVE 7

// Clock and line timing.
`define DPS_CLK_NS 50
`define DPS_LINE_NS 64000
`define DPS_NOM_ON_NS 28800
`define DPS_LINE_CYC (`DPS_LINE_NS / `DPS_CLK_NS)
`define DPS_NOM_ON_CYC (`DPS_NOM_ON_NS / `DPS_CLK_NS)
`define DPS_OFF_CYC (`DPS_LINE_CYC - `DPS_NOM_ON_CYC)
`define DPS_LC_W 11
`define DPS_NOM_ON 11'h240
`define DPS_ON_ZERO 11'h000
`define DPS_ON_FIRST 11'h001

// Sequence times: ramps in ms, discharge in us.
`define DPS_START_MS 160
`define DPS_ESS_MS 1175
`define DPS_STOP_MS 50
`define DPS_DIS_SHORT_US 18600
`define DPS_DIS_LONG_US 25000
`define DPS_MS_CYC(ms) ((ms) * 1000000 / `DPS_CLK_NS)
`define DPS_US_CYC(us) ((us) * 1000 / `DPS_CLK_NS)
`define DPS_STEP_W 24
`define DPS_DIS_W 20

`endif

// ### dps_pkg.sv
// Types shared by the deflection sequencer modules.
package dps_pkg;

  typedef enum logic [3:0] {
    ST_OFF    = 4'b0000,
    ST_START  = 4'b0001,
    ST_RUN    = 4'b0010,
    ST_SWSCAN = 4'b0011,
    ST_SWFLY  = 4'b0100,
    ST_STOP   = 4'b0101,
    ST_FWSCAN = 4'b0110,
    ST_FWFLY  = 4'b0111,
    ST_FAIL   = 4'b1000
  } dps_state_t;

endpackage

// ### dps_ramp.sv
// Ramp pacer: releases one on-time step at a line start once the step interval has run out.
`timescale 1ns/1ns
`include "dps_map.svh"
module dps_ramp (
  input wire logic sys_clk, // system clock
  input wire logic rst_b, // synchronous reset, active low
  input wire logic run, // ramp in progress
  input wire logic line_start, // first cycle of a drive line
  input wire logic [`DPS_STEP_W-1:0] interval, // cycles between steps
  output logic step // one-cycle step permission
);
  import dps_pkg::*;

  logic [`DPS_STEP_W-1:0] cnt_q;
  logic [`DPS_STEP_W-1:0] cnt_d;
  logic pend_q;
  logic pend_d;
  logic expire;

  assign expire = run && (cnt_q >= interval - `DPS_STEP_W'h1);
  assign step = pend_q && line_start;
  assign cnt_d = (!run || expire) ? `DPS_STEP_W'h0 : cnt_q + `DPS_STEP_W'h1;
  // A step that expires in the line-start cycle stays pending for the next line.
  assign pend_d = run && (expire || (pend_q && !line_start));

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      cnt_q <= `DPS_STEP_W'h0;
      pend_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      pend_q <= pend_d;
    end
  end
endmodule

// ### dps_top.sv
// Horizontal drive switch-on and switch-off sequencer with its control registers.
// Function
// R1 - Standby waits for scan, then flyback end
// R2 - Slow stop lowers on-time stepwise to zero
// R3 - Discharge forced when slow stop begins, if enabled
// R4 - Overscan hold or keep vertical running
// R5 - Stop about 50 ms; discharge 18.6/25 ms
// R6 - Supply fail: wait vertical, discharge, drive on; the code acts on it only in start and run, and discharges only if enabled
// R7 - Monitor raises supply fail on supply drop
// R8 - Below power-on reset, drive and discharge stop
// R9 - Start with one-period on-time, normal off-time
// R10 - On-time ramps to nominal in 160 ms
// R11 - Close phase loop only at nominal frequency
// R12 - Extra slow start stretches ramp to 1175 ms
// R13 - Flyback blocks drive only in normal run; the code blocks it in every state except start and stop
// R14 - On-time changes by whole periods, once per line
//
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`include "dps_map.svh"
module dps_top #(
  parameter int START_CYC = `DPS_MS_CYC(`DPS_START_MS), // normal ramp length
  parameter int ESS_CYC = `DPS_MS_CYC(`DPS_ESS_MS), // extra slow ramp length
  parameter int STOP_CYC = `DPS_MS_CYC(`DPS_STOP_MS), // slow stop length
  parameter int DIS_SHORT_CYC = `DPS_US_CYC(`DPS_DIS_SHORT_US), // short discharge
  parameter int DIS_LONG_CYC = `DPS_US_CYC(`DPS_DIS_LONG_US) // long discharge
) (
  input wire logic sys_clk, // system clock, 20 MHz
  input wire logic rst_b, // synchronous reset, active low
  input wire logic [`DPS_AW-1:0] reg_addr, // register byte address
  input wire logic [`DPS_DW-1:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [`DPS_DW-1:0] reg_rdata, // read data, cycle after the strobe
  input wire logic flyback_in, // horizontal flyback pulse pin
  input wire logic vert_flyback_in, // high during vertical flyback
  input wire logic supply_fail_input, // supply monitor fail pin
  output logic horizontal_drive_out, // drive to the output transistor
  output logic discharge_force, // force fixed beam discharge current
  output logic overscan_hold, // hold vertical in overscan
  output logic pll_close, // phase loop may close
  output dps_pkg::dps_state_t seq_state // sequencer state
);
  import dps_pkg::*;

  localparam int START_STEP = START_CYC / `DPS_NOM_ON_CYC;
  localparam int ESS_STEP = ESS_CYC / `DPS_NOM_ON_CYC;
  localparam int STOP_STEP = STOP_CYC / `DPS_NOM_ON_CYC;
  localparam int NPIN = 3;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] sync1_q;
  logic [NPIN-1:0] sync2_q;
  logic hfly;
  logic vfly;
  logic sfail;
  logic vfly_prev_q;
  logic vfly_rise;
  logic vfly_fall;

  assign pin_raw = {supply_fail_input, vert_flyback_in, flyback_in};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  assign hfly = sync2_q[0];
  assign vfly = sync2_q[1];
  assign sfail = sync2_q[2];
  // Rising edge ends the scan, falling edge ends the vertical flyback.
  assign vfly_rise = vfly && !vfly_prev_q;
  assign vfly_fall = !vfly && vfly_prev_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Control register and bus slave.

  logic [`DPS_CTRL_W-1:0] ctrl_q;
  logic [`DPS_CTRL_W-1:0] ctrl_d;
  logic standby;
  logic fbc_en;
  logic ovs_sel;
  logic tdis_sel;
  logic extra_slow_start;
  logic ctrl_wr;
  logic [`DPS_DW-1:0] rd_mux;
  logic [`DPS_DW-1:0] rdata_d;
  logic [`DPS_DW-1:0] status_word;
  logic [`DPS_LC_W-1:0] on_q;

  assign ctrl_wr = reg_wr && (reg_addr == `DPS_ADDR_CTRL);
  assign ctrl_d = ctrl_wr ? reg_wdata[`DPS_CTRL_W-1:0] : ctrl_q;
  assign standby = ctrl_q[`DPS_CTRL_STANDBY];
  assign fbc_en = ctrl_q[`DPS_CTRL_FBC_EN];
  assign ovs_sel = ctrl_q[`DPS_CTRL_OVS_SEL];
  assign tdis_sel = ctrl_q[`DPS_CTRL_TDIS_SEL];
  assign extra_slow_start = ctrl_q[`DPS_CTRL_ESS];

  always_comb begin
    status_word = '0;
    status_word[`DPS_ST_STATE_LO +: 4] = seq_state;
    status_word[`DPS_ST_PLL] = pll_close;
    status_word[`DPS_ST_DIS] = discharge_force;
    status_word[`DPS_ST_OVS] = overscan_hold;
    status_word[`DPS_ST_DRIVE] = horizontal_drive_out;
  end

  // Unmapped addresses read as zero; the bus never waits.
  assign rd_mux = (reg_addr == `DPS_ADDR_CTRL) ? {{(`DPS_DW-`DPS_CTRL_W){1'b0}}, ctrl_q} :
                  (reg_addr == `DPS_ADDR_STATUS) ? status_word :
                  (reg_addr == `DPS_ADDR_ONTIME) ? {{(`DPS_DW-`DPS_LC_W){1'b0}}, on_q} :
                  '0;
  assign rdata_d = reg_rd ? rd_mux : '0;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ctrl_q <= `DPS_CTRL_RESET;
      reg_rdata <= '0;
      vfly_prev_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      reg_rdata <= rdata_d;
      vfly_prev_q <= vfly;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Line counter: period is on-time plus the fixed normal off-time.

  logic [`DPS_LC_W-1:0] lc_q;
  logic [`DPS_LC_W-1:0] lc_d;
  logic [`DPS_LC_W-1:0] period;
  logic line_start;
  logic line_end;

  assign period = on_q + `DPS_LC_W'(`DPS_OFF_CYC);
  assign line_start = (lc_q == `DPS_ON_ZERO);
  assign line_end = (lc_q >= period - `DPS_ON_FIRST);
  assign lc_d = line_end ? `DPS_ON_ZERO : lc_q + `DPS_ON_FIRST;

  ////////////////////////////////////////////////////////////////////////////////
  // Ramp pacing.

  logic ramp_run;
  logic ramp_step;
  logic [`DPS_STEP_W-1:0] interval;

  assign ramp_run = (seq_state == ST_START) || (seq_state == ST_STOP);
  assign interval = (seq_state == ST_STOP) ? `DPS_STEP_W'(STOP_STEP) : // R5
                    extra_slow_start ? `DPS_STEP_W'(ESS_STEP) : // R12
                    `DPS_STEP_W'(START_STEP); // R10

  dps_ramp u_ramp (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .run(ramp_run),
    .line_start(line_start),
    .interval(interval),
    .step(ramp_step)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer.

  dps_state_t state_d;
  logic [`DPS_LC_W-1:0] on_d;
  logic fail_ok;

  // A supply failure during standby shutdown is left to the slow stop already under way.
  assign fail_ok = (seq_state == ST_START) || (seq_state == ST_RUN);

  always_comb begin
    state_d = seq_state;
    on_d = on_q;
    case (seq_state)
      ST_OFF: begin
        if (!standby) begin
          state_d = ST_START;
          on_d = `DPS_ON_FIRST; // R9
        end
      end
      ST_START: begin
        if (sfail) begin
          state_d = ST_FWSCAN;
        end else if (standby) begin
          state_d = ST_SWSCAN;
        end else if (ramp_step) begin
          on_d = on_q + `DPS_ON_FIRST; // R10 R14
          if (on_d == `DPS_NOM_ON) begin
            state_d = ST_RUN;
          end
        end
      end
      ST_RUN: begin
        if (sfail) begin
          state_d = ST_FWSCAN; // R6
        end else if (standby) begin
          state_d = ST_SWSCAN; // R1
        end
      end
      ST_SWSCAN: begin
        if (vfly_rise) begin
          state_d = ST_SWFLY; // R1
        end
      end
      ST_SWFLY: begin
        if (vfly_fall) begin
          state_d = ST_STOP; // R1
        end
      end
      ST_STOP: begin
        if (on_q == `DPS_ON_ZERO) begin
          state_d = ST_OFF;
        end else if (ramp_step) begin
          on_d = on_q - `DPS_ON_FIRST; // R2 R14
        end
      end
      ST_FWSCAN: begin
        if (vfly_rise) begin
          state_d = ST_FWFLY; // R6
        end
      end
      ST_FWFLY: begin
        if (vfly_fall) begin
          state_d = ST_FAIL; // R6
        end
      end
      ST_FAIL: begin
        state_d = ST_FAIL; // R6
      end
      default: begin
        state_d = ST_OFF;
        on_d = `DPS_ON_ZERO;
      end
    endcase
    if (!fail_ok && (state_d == ST_FWSCAN)) begin
      state_d = seq_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs: drive, discharge, overscan and phase loop release.

  logic [`DPS_DIS_W-1:0] dis_cnt_q;
  logic [`DPS_DIS_W-1:0] dis_cnt_d;
  logic [`DPS_DIS_W-1:0] dis_lim;
  logic drive_d;
  logic dis_d;
  logic ovs_d;
  logic shut_d;

  assign dis_lim = tdis_sel ? `DPS_DIS_W'(DIS_LONG_CYC) : `DPS_DIS_W'(DIS_SHORT_CYC); // R5
  assign dis_cnt_d = (seq_state != ST_STOP) ? '0 :
                     (dis_cnt_q < dis_lim) ? dis_cnt_q + `DPS_DIS_W'h1 : dis_cnt_q;
  // Flyback gating would cut short pulses during the ramps, so it is applied in every state except start and stop.
  assign drive_d = (on_q != `DPS_ON_ZERO) && (lc_q < on_q) &&
                   !(hfly && (seq_state != ST_START) && (seq_state != ST_STOP)); // R13
  assign dis_d = fbc_en && (((state_d == ST_STOP) && (dis_cnt_d < dis_lim)) || // R3 R5
                            (state_d == ST_FAIL)); // R6
  assign shut_d = (state_d == ST_STOP) || (state_d == ST_FAIL);
  assign ovs_d = ovs_sel && shut_d; // R4

  // Synchronous reset doubles as power-on reset: drive and discharge drop with it.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      seq_state <= ST_OFF;
      on_q <= `DPS_ON_ZERO;
      lc_q <= `DPS_ON_ZERO;
      dis_cnt_q <= '0;
      horizontal_drive_out <= 1'b0; // R8
      discharge_force <= 1'b0; // R8
      overscan_hold <= 1'b0;
      pll_close <= 1'b0;
    end else begin
      seq_state <= state_d;
      on_q <= on_d;
      lc_q <= lc_d;
      dis_cnt_q <= dis_cnt_d;
      horizontal_drive_out <= drive_d;
      discharge_force <= dis_d;
      overscan_hold <= ovs_d;
      pll_close <= (state_d == ST_RUN); // R11
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  a_stop_after_fly: assert property (@(posedge sys_clk) disable iff (!rst_b) // R1
    (seq_state == ST_STOP) && ($past(seq_state) != ST_STOP) |->
      ($past(seq_state) == ST_SWFLY) && $past(vfly_fall))
    else $error("slow stop began without a completed vertical flyback");

  a_stop_ramp_down: assert property (@(posedge sys_clk) disable iff (!rst_b) // R2
    (seq_state == ST_STOP) ##1 (seq_state == ST_STOP) |-> (on_q <= $past(on_q)))
    else $error("on-time rose during slow stop");

  a_dis_at_stop: assert property (@(posedge sys_clk) disable iff (!rst_b) // R3
    (seq_state == ST_SWFLY) && vfly_fall && fbc_en && !ctrl_wr |=> discharge_force)
    else $error("discharge not forced at start of slow stop");

  a_overscan_sel: assert property (@(posedge sys_clk) disable iff (!rst_b) // R4
    overscan_hold |-> $past(ovs_sel) && ((seq_state == ST_STOP) || (seq_state == ST_FAIL)))
    else $error("overscan hold without select bit or outside shutdown");

  a_dis_bounded: assert property (@(posedge sys_clk) disable iff (!rst_b) // R5
    (seq_state == ST_STOP) |-> (dis_cnt_q <= dis_lim))
    else $error("discharge counter past its limit");

  a_fail_drive_on: assert property (@(posedge sys_clk) disable iff (!rst_b) // R6
    (seq_state == ST_FAIL) ##1 (seq_state == ST_FAIL) |-> $stable(on_q) && (on_q != '0))
    else $error("drive changed after supply fail");

  a_start_one: assert property (@(posedge sys_clk) disable iff (!rst_b) // R9
    (seq_state == ST_OFF) && (state_d == ST_START) |=> (on_q == `DPS_ON_FIRST))
    else $error("switch-on did not start with one-period on-time");

  a_pll_nominal: assert property (@(posedge sys_clk) disable iff (!rst_b) // R11
    pll_close |-> (on_q == `DPS_NOM_ON))
    else $error("phase loop closed before nominal on-time");

  a_fly_gate: assert property (@(posedge sys_clk) disable iff (!rst_b) // R13
    (seq_state != ST_START) && (seq_state != ST_STOP) && hfly |=> !horizontal_drive_out)
    else $error("drive active during flyback outside the ramps");

  a_one_step: assert property (@(posedge sys_clk) disable iff (!rst_b) // R14
    ramp_run && ($past(seq_state) == seq_state) && !line_start |=> $stable(on_q))
    else $error("on-time changed away from a line start");

endmodule

// ### dps_far_model.sv
// Behavioural model of the horizontal output stage and the supply monitor.
`timescale 1ns/1ns
module dps_far_model (
  input wire logic sys_clk, // system clock
  input wire logic drive, // drive pulse from the sequencer
  input wire logic mains_off, // bench request: mains switched off
  output logic flyback, // horizontal flyback pulse
  output logic supply_fail // supply monitor output
);
  int cnt = 0;
  // Flyback follows the end of conduction; an undriven stage gives none, so the pin sits low.
  always_ff @(posedge sys_clk) begin
    if (drive) begin
      cnt <= 1;
    end else if (cnt != 0 && cnt < 150) begin
      cnt <= cnt + 1;
    end else begin
      cnt <= 0;
    end
  end
  assign flyback = (cnt >= 20 && cnt < 120);
  // The monitor reacts at once to the supply drop that follows mains switch-off.
  assign supply_fail = mains_off;
endmodule

// ### test_deflection_power_sequencer.sv
// Self-checking bench for the deflection power sequencer.
`timescale 1ns/1ns
`include "dps_map.svh"
module test_deflection_power_sequencer;
  import dps_pkg::*;
  localparam int DIS_S = 1000;
  localparam int DIS_L = 1500;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [`DPS_AW-1:0] reg_addr = 8'h00;
  logic [`DPS_DW-1:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic vert_flyback_in = 1'b0;
  logic mains_off = 1'b0;
  logic [`DPS_DW-1:0] reg_rdata;
  logic flyback_in, supply_fail_input, horizontal_drive_out;
  logic discharge_force, overscan_hold, pll_close;
  dps_state_t seq_state;
  int fails = 0, compares = 0, seed = 30585;
  int hi, lo, prev, sum, k, d;
  logic [31:0] rd;

  dps_top #(.START_CYC(5760), .ESS_CYC(864000), .STOP_CYC(2880), .DIS_SHORT_CYC(DIS_S),
    .DIS_LONG_CYC(DIS_L)) u_dps_top (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .flyback_in(flyback_in), .vert_flyback_in(vert_flyback_in),
    .supply_fail_input(supply_fail_input), .horizontal_drive_out(horizontal_drive_out),
    .discharge_force(discharge_force), .overscan_hold(overscan_hold), .pll_close(pll_close),
    .seq_state(seq_state));
  dps_far_model u_dps_far_model (.sys_clk(sys_clk), .drive(horizontal_drive_out),
    .mains_off(mains_off), .flyback(flyback_in), .supply_fail(supply_fail_input));

  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("comparisons %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe edge, so they are taken there.
  task automatic rdr(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  // Measures one drive pulse and the gap to the next; a silent drive ends on the bound.
  task automatic pulse(output int h, output int l);
    h = 0;
    l = 0;
    while (horizontal_drive_out !== 1'b1 && l < 3000) begin
      @(posedge sys_clk);
      #1 l++;
    end
    l = 0;
    while (horizontal_drive_out === 1'b1 && h < 3000) begin
      @(posedge sys_clk);
      #1 h++;
    end
    while (horizontal_drive_out !== 1'b1 && l < 3000) begin
      @(posedge sys_clk);
      #1 l++;
    end
  endtask

  task automatic vert(input logic v);
    @(posedge sys_clk);
    vert_flyback_in <= v;
    repeat (8) @(posedge sys_clk);
    #1;
  endtask

  function automatic logic [31:0] ctrl(input int stb, fbc, overscan_hold_select, tsel, extra_slow_start);
    return {27'h0, extra_slow_start[0], tsel[0], overscan_hold_select[0], fbc[0], stb[0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    #1 check(seq_state, ST_OFF, "state after reset");
    rdr(`DPS_ADDR_CTRL, rd);
    check(rd, 32'h1, "control reset value");
    rdr(8'h0c + 8'({$random(seed)} % 61 * 4), rd);
    check(rd, 32'h0, "unmapped read");
    wr(`DPS_ADDR_STATUS, 32'hff);
    rdr(`DPS_ADDR_STATUS, rd);
    check(rd, 32'h0, "status after ignored write");
    // The third pass shuts down with the fixed discharge disabled.
    for (int t = 0; t < 3; t++) begin
      wr(`DPS_ADDR_CTRL, ctrl(0, t < 2, t == 0, t == 1, 0));
      // The state follows the control register one edge after the write lands.
      @(posedge sys_clk);
      #1 check(seq_state, ST_START, "slow start entered");
      rdr(`DPS_ADDR_ONTIME, rd);
      check(rd, 32'h1, "first on-time");
      check(pll_close, 1'b0, "phase loop open in slow start");
      pulse(prev, lo);
      k = 3 + ({$random(seed)} % 4);
      for (int i = 0; i < k; i++) begin
        pulse(hi, lo);
        check(lo, `DPS_OFF_CYC, "off-time in slow start");
        check(hi - prev, 1, "on-time step per line");
        prev = hi;
      end
      wr(`DPS_ADDR_CTRL, ctrl(1, t < 2, t == 0, t == 1, 0));
      pulse(hi, lo);
      pulse(hi, lo);
      check(seq_state, ST_SWSCAN, "waiting for scan end");
      check(hi > 0, 1, "drive kept during scan");
      vert(1'b1);
      check(seq_state, ST_SWFLY, "waiting for flyback end");
      check(discharge_force, 1'b0, "no discharge before stop");
      vert(1'b0);
      check(seq_state, ST_STOP, "slow stop after flyback");
      check(discharge_force, t < 2, "discharge with slow stop");
      check(overscan_hold, t == 0, "overscan select");
      d = 0;
      while (discharge_force === 1'b1 && d < 5000) begin
        @(posedge sys_clk);
        #1 d++;
      end
      // Five cycles of the discharge had passed before the count started; seven are added back.
      if (t < 2) begin
        d = d + 8 - 1;
        check(d >= (t ? DIS_L : DIS_S) - 2 && d <= (t ? DIS_L : DIS_S) + 2, 1,
          "discharge length");
      end else begin
        check(d, 0, "no discharge when disabled");
      end
      prev = 3000;
      for (int i = 0; i < 600 && prev > 0; i++) begin
        pulse(hi, lo);
        if (prev < 3000) check(prev - hi <= 1 && hi <= prev, 1, "stop step");
        prev = hi;
      end
      check(seq_state, ST_OFF, "off after slow stop");
    end
    wr(`DPS_ADDR_CTRL, ctrl(0, 1, 0, 1, 1));
    pulse(prev, lo);
    sum = 0;
    for (int i = 0; i < 5; i++) begin
      pulse(hi, lo);
      check(hi - prev <= 1 && hi >= prev, 1, "extra slow step");
      sum += hi - prev;
      prev = hi;
    end
    check(sum >= 1 && sum <= 2, 1, "extra slow rate");
    @(posedge sys_clk);
    mains_off <= 1'b1;
    repeat (6) @(posedge sys_clk);
    #1 check(seq_state, ST_FWSCAN, "fail waits for scan");
    check(discharge_force, 1'b0, "no discharge before flyback end");
    vert(1'b1);
    check(seq_state, ST_FWFLY, "fail waits for flyback");
    vert(1'b0);
    check(seq_state, ST_FAIL, "fail state");
    check(discharge_force, 1'b1, "fail discharge");
    check(overscan_hold, 1'b0, "vertical keeps running");
    pulse(hi, lo);
    pulse(hi, lo);
    check(hi > 0, 1, "drive runs on in fail");
    check(discharge_force, 1'b1, "fail discharge held");
    @(posedge sys_clk);
    rst_b <= 1'b0;
    mains_off <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 check(horizontal_drive_out, 1'b0, "drive stops at reset");
    check(discharge_force, 1'b0, "discharge stops at reset");
    finish_test;
  end

  initial begin
    #(50 * 95000);
    fails++;
    finish_test;
  end
endmodule
